// *** dual_port_block_ram_pkg.sv ***
// Shared constants and configuration checks for the dual-port block RAM.
package dual_port_block_ram_pkg;
    localparam int TOTAL_BITS = 4608;
    localparam int PLAIN_BITS = 4096;
    localparam int MAX_WIDTH = 36;
    localparam int TDP_MAX_WIDTH = 18;
    localparam int MASKED_MIN_WIDTH = 16;
    localparam int LANE_PARITY = 9;
    localparam int LANE_PLAIN = 8;
    localparam int MASK_BITS = 4;
    localparam int ADDR_BITS = 12;

    function automatic bit isParity(input int w);
        return (w == 9) || (w == 18) || (w == 36);
    endfunction

    function automatic bit legalWidth(input int w);
        return (w == 1) || (w == 2) || (w == 4) || (w == 8) || (w == 16) || (w == 32) || isParity(w);
    endfunction
endpackage

// *** dual_port_block_ram.sv ***
// Dual-port block RAM with mixed widths, byte masking, clock modes and shift-register mode.
// What this block does
// - Shift mode advances one position each cycle that ceInA is high.
// - Last tap leaves for chaining into next block.
// - Ports take the nine documented depth-width shapes.
// - True dual-port rejects 32 and 36 wide.
// - Parity widths pair only with parity widths.
// - Byte mask only for 16/18/32/36 writes.
// - Masked-off bytes keep their old contents.
// - Mask bits pick 9-bit lanes upward.
// - Mask bits pick 8-bit lanes for 16/32.
// - Input registers always; output register bypassable.
// - Independent mode: each port on its own controls.
// - Independent mode: one enable, one clear per port.
// - In/out mode: input and output groups separate.
// - In/out mode: separate enables and clears per group.
// - Simple dual read-enable register has no clear.
// - Each byte carries an optional parity bit.
// - Both ports access in parallel, any mix in true dual-port; simple dual-port writes on A only and reads on B only.
// - Write strobe derived from registered write enable.
module dual_port_block_ram
    import dual_port_block_ram_pkg::*;
#(
    parameter int WIDTH_A = 18,
    parameter int WIDTH_B = 18,
    parameter bit TRUE_DUAL = 1'b1,
    parameter bit OUT_REG_A = 1'b1,
    parameter bit OUT_REG_B = 1'b1,
    parameter bit SHIFT_MODE = 1'b0,
    parameter int SR_WIDTH = 8,
    parameter int SR_LEN = 64,
    parameter int SR_TAPS = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ioClkMode,
    input wire logic ceInA,
    input wire logic ceOutA,
    input wire logic clrInA,
    input wire logic clrOutA,
    input wire logic weA,
    input wire logic [ADDR_BITS-1:0] addrA,
    input wire logic [MASK_BITS-1:0] maskA,
    input wire logic [MAX_WIDTH-1:0] dinA,
    output logic [MAX_WIDTH-1:0] qA,
    input wire logic ceInB,
    input wire logic ceOutB,
    input wire logic clrInB,
    input wire logic clrOutB,
    input wire logic weB,
    input wire logic rdEnB,
    input wire logic [ADDR_BITS-1:0] addrB,
    input wire logic [MASK_BITS-1:0] maskB,
    input wire logic [MAX_WIDTH-1:0] dinB,
    output logic [MAX_WIDTH-1:0] qB,
    input wire logic [MAX_WIDTH-1:0] shiftIn,
    output logic [MAX_WIDTH-1:0] shiftTaps,
    output logic [MAX_WIDTH-1:0] shiftOut,
    output logic cfgError
);
    // Illegal shapes are refused: the flag is raised and no write ever lands.
    localparam bit SR_BAD = SHIFT_MODE && ((SR_WIDTH * SR_LEN * SR_TAPS > TOTAL_BITS)
        || (SR_WIDTH * SR_TAPS >= MAX_WIDTH));
    localparam bit CFG_BAD = !legalWidth(WIDTH_A) || !legalWidth(WIDTH_B)
        || (isParity(WIDTH_A) != isParity(WIDTH_B))
        || (TRUE_DUAL && ((WIDTH_A > TDP_MAX_WIDTH) || (WIDTH_B > TDP_MAX_WIDTH)))
        || SR_BAD;
    localparam bit RAM_ON = !CFG_BAD && !SHIFT_MODE;
    localparam bit SR_ON = !CFG_BAD && SHIFT_MODE;

    logic rstMeta_r;
    logic rstSync_r;
    logic [TOTAL_BITS-1:0] mem;
    logic aWe_r, bWe_r, rdEnB_r;
    logic [ADDR_BITS-1:0] aAddr_r, bAddr_r;
    logic [MASK_BITS-1:0] aMask_r, bMask_r;
    logic [MAX_WIDTH-1:0] aDin_r, bDin_r, aRd_r, bRd_r;
    logic [ADDR_BITS-1:0] srPtr_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release and clear routing.

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end

    // Independent mode lets the input-side controls govern the output side too.
    logic aInClr, bInClr, aOutClr, bOutClr, aCeOut, bCeOut;
    assign aInClr = !rstSync_r || clrInA;
    assign bInClr = !rstSync_r || clrInB;
    assign aOutClr = !rstSync_r || (ioClkMode ? clrOutA : clrInA);
    assign bOutClr = !rstSync_r || (ioClkMode ? clrOutB : clrInB);
    assign aCeOut = ioClkMode ? ceOutA : ceInA;
    assign bCeOut = ioClkMode ? ceOutB : ceInB;

    ////////////////////////////////////////////////////////////////////////////////
    // Addressing helpers.

    // Plain widths skip the ninth bit of each stored byte; parity widths use it.
    function automatic int bitIdx(input int w, input logic [ADDR_BITS-1:0] addr, input int i);
        int b;
        b = (int'(addr) * w + i) % (isParity(w) ? TOTAL_BITS : PLAIN_BITS);
        return isParity(w) ? b : (b / LANE_PLAIN) * LANE_PARITY + (b % LANE_PLAIN);
    endfunction

    function automatic bit laneOn(input int w, input logic [MASK_BITS-1:0] mask, input int i);
        if (w < MASKED_MIN_WIDTH) begin
            return 1'b1;
        end
        return mask[i / (isParity(w) ? LANE_PARITY : LANE_PLAIN)];
    endfunction

    function automatic logic [MAX_WIDTH-1:0] readWord(input int w, input logic [ADDR_BITS-1:0] addr);
        logic [MAX_WIDTH-1:0] d;
        d = '0;
        for (int i = 0; i < w; i++) begin
            d[i] = mem[bitIdx(w, addr, i)];
        end
        return d;
    endfunction

    function automatic int srBase(input int k, input logic [ADDR_BITS-1:0] ptr);
        return (k * SR_LEN + int'(ptr)) * SR_WIDTH;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Input registers, one set per port.

    always_ff @(posedge clk_sys or posedge aInClr) begin
        if (aInClr) begin
            aWe_r <= 1'b0;
            aAddr_r <= '0;
            aMask_r <= '0;
            aDin_r <= '0;
        end else if (ceInA) begin
            aWe_r <= weA;
            aAddr_r <= addrA;
            aMask_r <= maskA;
            aDin_r <= dinA;
        end
    end

    always_ff @(posedge clk_sys or posedge bInClr) begin
        if (bInClr) begin
            bWe_r <= 1'b0;
            bAddr_r <= '0;
            bMask_r <= '0;
            bDin_r <= '0;
        end else if (ceInB) begin
            bWe_r <= weB && TRUE_DUAL;
            bAddr_r <= addrB;
            bMask_r <= maskB;
            bDin_r <= dinB;
        end
    end

    // The read enable of the simple dual-port read side only follows the reset.
    always_ff @(posedge clk_sys or negedge rstSync_r) begin
        if (!rstSync_r) begin
            rdEnB_r <= 1'b0;
        end else if (ceInB) begin
            rdEnB_r <= rdEnB;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Storage core. Reads sample the array before this edge's writes land, so a
    // colliding read sees old data; colliding writes let port B win when it is at
    // least as wide as port A, which users must treat as undefined.

    always_ff @(posedge clk_sys) begin
        if (RAM_ON && rstSync_r) begin
            for (int i = 0; i < MAX_WIDTH; i++) begin
                if (aWe_r && i < WIDTH_A && laneOn(WIDTH_A, aMask_r, i)) begin
                    mem[bitIdx(WIDTH_A, aAddr_r, i)] <= aDin_r[i];
                end
                if (bWe_r && i < WIDTH_B && laneOn(WIDTH_B, bMask_r, i)) begin
                    mem[bitIdx(WIDTH_B, bAddr_r, i)] <= bDin_r[i];
                end
            end
        end
        if (SR_ON && rstSync_r && ceInA) begin
            // Old word read and new word written at one edge stands in for the
            // falling-edge write and rising-edge read of the real array.
            for (int k = 0; k < SR_TAPS; k++) begin
                mem[srBase(k, srPtr_r) +: SR_WIDTH] <= (k == 0) ? shiftIn[SR_WIDTH-1:0]
                    : mem[srBase(k - 1, srPtr_r) +: SR_WIDTH];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge aInClr) begin
        if (aInClr) begin
            srPtr_r <= '0;
        end else if (SR_ON && ceInA) begin
            srPtr_r <= (int'(srPtr_r) == SR_LEN - 1) ? '0 : srPtr_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output registers; a bypassed port loads straight from the array.

    always_ff @(posedge clk_sys or posedge aOutClr) begin
        if (aOutClr) begin
            aRd_r <= '0;
            qA <= '0;
        end else if (aCeOut && TRUE_DUAL) begin
            aRd_r <= readWord(WIDTH_A, aAddr_r);
            qA <= OUT_REG_A ? aRd_r : readWord(WIDTH_A, aAddr_r);
        end
    end

    always_ff @(posedge clk_sys or posedge bOutClr) begin
        if (bOutClr) begin
            bRd_r <= '0;
            qB <= '0;
        end else if (bCeOut && (TRUE_DUAL || rdEnB_r)) begin
            bRd_r <= readWord(WIDTH_B, bAddr_r);
            qB <= OUT_REG_B ? bRd_r : readWord(WIDTH_B, bAddr_r);
        end
    end

    always_ff @(posedge clk_sys or posedge aOutClr) begin
        if (aOutClr) begin
            shiftTaps <= '0;
            shiftOut <= '0;
        end else if (SR_ON && aCeOut) begin
            for (int k = 0; k < SR_TAPS; k++) begin
                shiftTaps[k * SR_WIDTH +: SR_WIDTH] <= mem[srBase(k, srPtr_r) +: SR_WIDTH];
            end
            shiftOut <= {{(MAX_WIDTH - SR_WIDTH){1'b0}}, mem[srBase(SR_TAPS - 1, srPtr_r) +: SR_WIDTH]};
        end
    end

    // The flag resets to the configuration verdict, so it is valid from reset on.
    always_ff @(posedge clk_sys or negedge rstSync_r) begin
        if (!rstSync_r) begin
            cfgError <= CFG_BAD;
        end else begin
            cfgError <= CFG_BAD;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstSync_r);

    property p_clr_zero; clrInA |-> (aWe_r == 1'b0 && aAddr_r == '0); endproperty
    a_clr_zero: assert property (p_clr_zero) else $error("Clear did not zero port A inputs.");

    property p_hold_in; !ceInA && !clrInA ##1 !clrInA |-> $stable(aAddr_r) && $stable(aDin_r); endproperty
    a_hold_in: assert property (p_hold_in) else $error("Port A input registers moved while disabled.");

    property p_rden_noclr;
        clrInB && !$past(clrInB) && !$past(ceInB) |-> rdEnB_r == $past(rdEnB_r);
    endproperty
    a_rden_noclr: assert property (p_rden_noclr) else $error("Read enable register was cleared.");

    property p_tdp_reject; (TRUE_DUAL && (WIDTH_A > TDP_MAX_WIDTH || WIDTH_B > TDP_MAX_WIDTH)) |-> cfgError; endproperty
    a_tdp_reject: assert property (p_tdp_reject) else $error("Wide true dual-port shape not rejected.");

    property p_mix_reject; (isParity(WIDTH_A) != isParity(WIDTH_B)) |-> cfgError; endproperty
    a_mix_reject: assert property (p_mix_reject) else $error("Mixed width families not rejected.");

    property p_mask_keep;
        RAM_ON && aWe_r && !bWe_r && WIDTH_A >= MASKED_MIN_WIDTH && !aMask_r[0]
            |=> mem[bitIdx(WIDTH_A, $past(aAddr_r), 0)] == $past(mem[bitIdx(WIDTH_A, aAddr_r, 0)]);
    endproperty
    a_mask_keep: assert property (p_mask_keep) else $error("Masked-off lane was overwritten.");

    property p_write_lands;
        RAM_ON && aWe_r && !bWe_r && laneOn(WIDTH_A, aMask_r, 0)
            |=> mem[bitIdx(WIDTH_A, $past(aAddr_r), 0)] == $past(aDin_r[0]);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("Registered write did not land.");

    property p_ptr_step;
        SR_ON && ceInA && !clrInA ##1 !clrInA
            |-> srPtr_r == ((int'($past(srPtr_r)) == SR_LEN - 1) ? '0 : $past(srPtr_r) + 1'b1);
    endproperty
    a_ptr_step: assert property (p_ptr_step) else $error("Shift pointer did not advance by one.");

    property p_out_hold; ioClkMode && !ceOutA && !clrOutA ##1 !clrOutA |-> $stable(qA); endproperty
    a_out_hold: assert property (p_out_hold) else $error("Port A output moved while its enable was low.");
endmodule

// *** fabric_user_model.sv ***
// Port-B user logic in the surrounding fabric that issues read and write requests.
module fabric_user_model (
    input wire logic clk_sys,
    output logic ceInB,
    output logic ceOutB,
    output logic clrInB,
    output logic clrOutB,
    output logic weB,
    output logic [11:0] addrB,
    output logic [3:0] maskB,
    output logic [35:0] dinB
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        ceInB = 1'b1;
        ceOutB = 1'b1;
        clrInB = 1'b0;
        clrOutB = 1'b0;
        weB = 1'b0;
        addrB = 12'h000;
        maskB = 4'h0;
        dinB = 36'h0;
    end

    // A read leaves the data lines toggling so a stale value is never mistaken for a write.
    task automatic op(input logic w, input logic [11:0] a, input logic [35:0] d, input logic [3:0] m);
        @(posedge clk_sys);
        #1;
        weB = w;
        addrB = a;
        maskB = m;
        dinB = w ? d : ~dinB;
    endtask

    // The enable drops one cycle ahead so that a clear of the read-enable register cannot hide.
    task automatic clrPulse();
        @(posedge clk_sys);
        #1;
        ceInB = 1'b0;
        @(posedge clk_sys);
        #1;
        clrInB = 1'b1;
        clrOutB = 1'b1;
        @(posedge clk_sys);
        #1;
        clrInB = 1'b0;
        clrOutB = 1'b0;
        ceInB = 1'b1;
    endtask
endmodule

// *** dual_port_block_ram_tb.sv ***
// Self-checking bench comparing the dual-port block RAM with a lane-masked memory model.
module dual_port_block_ram_tb;
    import dual_port_block_ram_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys, rst_n, ioClkMode, ceInA, ceOutA, clrInA, clrOutA, weA, cfgError;
    logic ceInB, ceOutB, clrInB, clrOutB, weB;
    logic [ADDR_BITS-1:0] addrA, addrB, a;
    logic [MASK_BITS-1:0] maskA, maskB, m;
    logic [MAX_WIDTH-1:0] dinA, dinB, qA, qB, d, old;
    logic [MAX_WIDTH-1:0] mdl [4];
    int error_cnt = 0;
    int check_count = 0;
    bit [31:0] seed = 32'd13;
    localparam int SRW = 8;
    localparam int SRL = 4;
    localparam int SRT = 4;
    logic cfgBad, srCe;
    logic [MAX_WIDTH-1:0] srIn, srTaps, srOut;
    logic [7:0] srQ [$];

    dual_port_block_ram #(.WIDTH_A(18), .WIDTH_B(18), .TRUE_DUAL(1'b1)) i_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .ioClkMode(ioClkMode), .ceInA(ceInA), .ceOutA(ceOutA),
        .clrInA(clrInA), .clrOutA(clrOutA), .weA(weA), .addrA(addrA), .maskA(maskA), .dinA(dinA), .qA(qA),
        .ceInB(ceInB), .ceOutB(ceOutB), .clrInB(clrInB), .clrOutB(clrOutB), .weB(weB), .rdEnB(1'b1),
        .addrB(addrB), .maskB(maskB), .dinB(dinB), .qB(qB), .shiftIn(36'h0), .shiftTaps(), .shiftOut(),
        .cfgError(cfgError));

    // Wide true dual-port shape with mixed width families must be flagged.
    dual_port_block_ram #(.WIDTH_A(36), .WIDTH_B(16), .TRUE_DUAL(1'b1)) i_bad (
        .clk_sys(clk_sys), .rst_n(rst_n), .ioClkMode(1'b0), .ceInA(1'b1), .ceOutA(1'b1), .clrInA(1'b0),
        .clrOutA(1'b0), .weA(1'b0), .addrA(12'h000), .maskA(4'h0), .dinA(36'h0), .qA(), .ceInB(1'b1),
        .ceOutB(1'b1), .clrInB(1'b0), .clrOutB(1'b0), .weB(1'b0), .rdEnB(1'b1), .addrB(12'h000),
        .maskB(4'h0), .dinB(36'h0), .qB(), .shiftIn(36'h0), .shiftTaps(), .shiftOut(), .cfgError(cfgBad));

    // Shift shape 8 x 4 x 4 keeps both the storage total and the tap width inside their limits.
    dual_port_block_ram #(.SHIFT_MODE(1'b1), .SR_WIDTH(SRW), .SR_LEN(SRL), .SR_TAPS(SRT)) i_sr (
        .clk_sys(clk_sys), .rst_n(rst_n), .ioClkMode(1'b0), .ceInA(srCe), .ceOutA(1'b1), .clrInA(1'b0),
        .clrOutA(1'b0), .weA(1'b0), .addrA(12'h000), .maskA(4'h0), .dinA(36'h0), .qA(), .ceInB(1'b1),
        .ceOutB(1'b1), .clrInB(1'b0), .clrOutB(1'b0), .weB(1'b0), .rdEnB(1'b1), .addrB(12'h000),
        .maskB(4'h0), .dinB(36'h0), .qB(), .shiftIn(srIn), .shiftTaps(srTaps), .shiftOut(srOut),
        .cfgError());

    fabric_user_model i_user (.clk_sys(clk_sys), .ceInB(ceInB), .ceOutB(ceOutB), .clrInB(clrInB),
        .clrOutB(clrOutB), .weB(weB), .addrB(addrB), .maskB(maskB), .dinB(dinB));

    function automatic bit [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Only the two low lanes exist at width 18, so upper mask bits must have no effect.
    function automatic void wr(input logic [11:0] ad, input logic [35:0] dv, input logic [3:0] mv);
        for (int k = 0; k < 2; k++) begin
            if (mv[k]) mdl[ad][9*k +: 9] = dv[9*k +: 9];
        end
    endfunction

    task automatic opA(input logic w, input logic [11:0] ad, input logic [35:0] dv, input logic [3:0] mv);
        @(posedge clk_sys);
        #1;
        weA = w;
        addrA = ad;
        maskA = mv;
        dinA = dv;
    endtask

    task automatic settle();
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    task automatic chk(input string n, input logic [35:0] e, input logic [35:0] s);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        conclude();
    end

    initial begin
        rst_n = 1'b0;
        ioClkMode = 1'b0;
        ceInA = 1'b1;
        ceOutA = 1'b1;
        clrInA = 1'b0;
        clrOutA = 1'b0;
        weA = 1'b0;
        addrA = 12'h000;
        maskA = 4'h0;
        dinA = 36'h0;
        srCe = 1'b0;
        srIn = 36'h0;
        foreach (mdl[k]) mdl[k] = '0;
        repeat (20) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("cfgError", 36'h0, {35'h0, cfgError});
        chk("cfgBad", 36'h1, {35'h0, cfgBad});
        for (int i = 0; i < 14; i++) begin
            a = (i < 4) ? 12'(i) : 12'(rnd() % 4);
            d = 36'(rnd() & 32'h3ffff);
            m = (i < 4) ? 4'hf : 4'(rnd());
            old = mdl[a];
            if (i % 2) fork opA(0, a, 36'h0, 4'h0); i_user.op(1, a, d, m); join
            else fork opA(1, a, d, m); i_user.op(0, a, 36'h0, 4'h0); join
            settle();
            if (i >= 4) chk("same-address old data", old, (i % 2) ? qA : qB);
            wr(a, d, m);
            fork opA(0, a, 36'h0, 4'h0); i_user.op(0, a, 36'h0, 4'h0); join
            settle();
            chk("qA readback", mdl[a], qA);
            chk("qB readback", mdl[a], qB);
        end
        $display("masked writes on both ports done");
        for (int md = 0; md < 2; md++) begin
            ioClkMode = 1'(md);
            opA(0, 12'h001, 36'h0, 4'h0);
            settle();
            if (md == 0) ceInA = 1'b0;
            else ceOutA = 1'b0;
            addrA = 12'h002;
            repeat (4) @(posedge clk_sys);
            #1;
            chk("qA held", mdl[1], qA);
            if (md == 0) clrInA = 1'b1;
            else clrOutA = 1'b1;
            #1;
            chk("qA cleared", 36'h0, qA);
            @(posedge clk_sys);
            #1;
            clrInA = 1'b0;
            clrOutA = 1'b0;
            ceInA = 1'b1;
            ceOutA = 1'b1;
            opA(0, 12'h001, 36'h0, 4'h0);
            settle();
            chk("memory kept after clear", mdl[1], qA);
            $display("mode %0d hold and clear done", md);
        end
        i_user.clrPulse();
        chk("qB cleared", 36'h0, qB);
        i_user.op(0, 12'h001, 36'h0, 4'h0);
        settle();
        chk("qB memory kept after clear", mdl[1], qB);
        $display("port B clear done");
        srCe = 1'b1;
        for (int s = 0; s < 40; s++) begin
            if (srQ.size() == SRT * SRL + 1) begin
                for (int k = 0; k < SRT; k++) begin
                    chk("shift tap", 36'(srQ[SRT * SRL - (k + 1) * SRL]), 36'(srTaps[k * SRW +: SRW]));
                end
                chk("shift out", 36'(srQ.pop_front()), srOut);
            end
            srIn = 36'(rnd() & 32'hff);
            srQ.push_back(srIn[7:0]);
            @(posedge clk_sys);
            #1;
        end
        $display("shift register taps done");
        conclude();
    end
endmodule
